/* File: src/hlec_event_ctrl.sv */
// layer-2 hdlc event and command logic with two-pool receive and transmit buffers
//
// Behaviour
// - receive and transmit buffers each hold two 32-byte pools under fifo control
// - a filled pool of an unfinished frame sets receive_pool_full in main status
// - frame end sets receive_message_end; count in bits 4-0 of byte count register
// - bytes arriving with no free pool are dropped; the frame end then sets receive_frame_overflow
// - auto mode protocol errors set protocol_error in extended status
// - transmit_pool_ready is set when more octets may be written
// - auto mode i-frame-close raises pool ready only after peer s-frame ack
// - transmission error, or auto mode peer reject while a close waits for ack, sets transmit_message_repeat
// - buffer empty before message end aborts frame, sets transmit_data_underrun
// - auto mode rr or rnr status change sets receive_status_change
// - timer flag on external expiry, or in auto mode t200 plus n200 expiry
// - command codes: 80 ack, 40 rx reset, 20 rnr, 10 timer, 08, 04, 02, 01
// - pool-full or end events wait while a previous one is unacknowledged
// - transmitter reset clears buffer and aborts frame with seven ones
`timescale 1ns/100ps
module hlec_event_ctrl
  import hlec_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  output logic irq_out,
  // receive side from the serial deframer
  input wire logic rx_byte_valid_in,
  input wire logic [7:0] rx_byte_in,
  input wire logic rx_frame_end_in,
  input wire logic rx_protocol_err_in,
  input wire logic rx_status_change_in,
  input wire logic rx_peer_ack_in,
  input wire logic rx_peer_reject_in,
  input wire logic tx_line_err_in,
  input wire logic ext_timer_expired_in,
  input wire logic t200_n200_expired_in,
  // transmit side towards the serial framer
  input wire logic tx_byte_ready_in,
  output logic tx_byte_valid_out,
  output logic [7:0] tx_byte_out,
  output logic tx_frame_end_out,
  output logic tx_abort_out,
  output logic rx_not_ready_out,
  output logic timer_start_out
);
  logic [7:0] rx_mem [0:2*HLEC_POOL_BYTES-1];
  logic [7:0] tx_mem [0:2*HLEC_POOL_BYTES-1];
  logic [6:0] rx_wcnt_r, rx_rcnt_r, rx_avail_r;
  logic [5:0] rx_rptr_r, rx_wptr_r;
  logic [6:0] tx_cnt_r;
  logic [5:0] tx_wptr_r, tx_rptr_r;
  logic [6:0] tx_rel_r;
  logic [7:0] main_r, ext_r, mask_r, ext_mask_r, mode_r, count_r;
  logic pend_evt_r, pend_end_r, wait_ack_r, pend_valid_r;
  logic [4:0] pend_cnt_r;
  logic xme_r, auto_close_r, cmd_rx_ack, rx_full, rx_pool_done;
  hlec_tx_t tx_state_r;
  logic [2:0] abort_cnt_r;
  logic auto_mode;
  // remembers that bytes of the current frame were lost, so its end reports overflow
  logic rx_drop_r;
  logic [7:0] cmd;

  assign auto_mode = mode_r[0];
  assign cmd = (wr_in && addr_in == HLEC_ADDR_COMMAND) ? wdata_in : 8'h00;
  assign cmd_rx_ack = cmd[HLEC_CMD_RMC];
  // full counts the pool being written plus blocks the host has not released yet
  assign rx_full = (rx_wcnt_r + rx_avail_r) >= 7'(2 * HLEC_POOL_BYTES);

  function automatic logic [5:0] hlec_inc(input logic [5:0] p);
    hlec_inc = p + 6'h01;
  endfunction : hlec_inc

  // receive buffer write side: a pool completes after 32 bytes or at frame end
  assign rx_pool_done = rx_byte_valid_in && !rx_full && rx_wcnt_r[4:0] == 5'h1F;

  always_ff @(posedge ref_clk_in) begin
    if (rst_in || cmd[HLEC_CMD_RECEIVER_RESET]) begin
      rx_wptr_r <= 6'h00;
      rx_wcnt_r <= 7'h00;
      rx_drop_r <= 1'b0;
    end else begin
      if (rx_byte_valid_in && rx_full)
        rx_drop_r <= 1'b1;
      if (rx_byte_valid_in && !rx_full) begin
        rx_mem[rx_wptr_r] <= rx_byte_in;
        rx_wptr_r <= hlec_inc(rx_wptr_r);
        rx_wcnt_r <= rx_pool_done ? 7'h00 : rx_wcnt_r + 7'h01;
      end
      // the frame end closes the drop window, the next frame starts clean
      if (rx_frame_end_in) begin
        rx_wcnt_r <= 7'h00;
        rx_drop_r <= 1'b0;
      end
    end
  end

  // handed-over blocks: pend holds one event that waits for the previous ack
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || cmd[HLEC_CMD_RECEIVER_RESET]) begin
      rx_avail_r <= 7'h00;
      rx_rptr_r <= 6'h00;
      rx_rcnt_r <= 7'h00;
      wait_ack_r <= 1'b0;
      pend_valid_r <= 1'b0;
      pend_end_r <= 1'b0;
      pend_cnt_r <= 5'h00;
      count_r <= 8'h00;
    end else begin
      if (rd_in && addr_in == HLEC_ADDR_RX_BUF && rx_avail_r != 7'h00)
        rx_rptr_r <= hlec_inc(rx_rptr_r);
      if (cmd_rx_ack && wait_ack_r) begin
        wait_ack_r <= pend_valid_r;
        pend_valid_r <= 1'b0;
        rx_avail_r <= rx_avail_r - rx_rcnt_r;
        rx_rcnt_r <= pend_end_r ? {2'b00, pend_cnt_r} : 7'(HLEC_POOL_BYTES);
        if (pend_valid_r && pend_end_r)
          count_r <= {3'b000, pend_cnt_r};
      end
      if (rx_pool_done || (rx_frame_end_in && rx_wcnt_r != 7'h00)) begin
        if (!wait_ack_r || (cmd_rx_ack && !pend_valid_r)) begin
          // nothing outstanding after this edge: the event is handed over at once
          wait_ack_r <= 1'b1;
          pend_valid_r <= 1'b0;
          rx_rcnt_r <= rx_frame_end_in && !rx_pool_done ? rx_wcnt_r : 7'(HLEC_POOL_BYTES);
          if (rx_frame_end_in)
            count_r <= {3'b000, rx_wcnt_r[4:0]};
        end else if (!pend_valid_r || cmd_rx_ack) begin
          // parked until the host acknowledges the block it is reading
          pend_valid_r <= 1'b1;
          pend_end_r <= rx_frame_end_in;
          pend_cnt_r <= rx_pool_done ? 5'h00 : rx_wcnt_r[4:0];
        end
        rx_avail_r <= rx_avail_r + (rx_pool_done ? 7'(HLEC_POOL_BYTES) : rx_wcnt_r)
          - ((cmd_rx_ack && wait_ack_r) ? rx_rcnt_r : 7'h00);
      end
    end
  end

  // transmit buffer: host writes, framer drains, sub-blocks released by commands
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || cmd[HLEC_CMD_TRANSMITTER_RESET]) begin
      tx_wptr_r <= 6'h00;
      tx_rptr_r <= 6'h00;
      tx_cnt_r <= 7'h00;
      tx_rel_r <= 7'h00;
    end else begin
      if (wr_in && addr_in == HLEC_ADDR_TX_BUF && tx_cnt_r < 7'(2 * HLEC_POOL_BYTES)) begin
        tx_mem[tx_wptr_r] <= wdata_in;
        tx_wptr_r <= hlec_inc(tx_wptr_r);
      end
      tx_cnt_r <= tx_cnt_r
        + 7'(wr_in && addr_in == HLEC_ADDR_TX_BUF && tx_cnt_r < 7'(2 * HLEC_POOL_BYTES))
        - 7'(tx_byte_valid_out && tx_byte_ready_in);
      if (tx_byte_valid_out && tx_byte_ready_in)
        tx_rptr_r <= hlec_inc(tx_rptr_r);
      if (cmd[HLEC_CMD_XTF] || cmd[HLEC_CMD_XIF])
        tx_rel_r <= tx_cnt_r - 7'(tx_byte_valid_out && tx_byte_ready_in);
      else if (tx_byte_valid_out && tx_byte_ready_in)
        tx_rel_r <= tx_rel_r - 7'h01;
      else if (tx_state_r == HLEC_TX_ABORT)
        tx_rel_r <= 7'h00;
    end
  end

  // transmit sequencing
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      tx_state_r <= HLEC_TX_IDLE;
      xme_r <= 1'b0;
      auto_close_r <= 1'b0;
      abort_cnt_r <= 3'h0;
    end else if (cmd[HLEC_CMD_TRANSMITTER_RESET]) begin
      tx_state_r <= tx_state_r == HLEC_TX_SEND ? HLEC_TX_ABORT : HLEC_TX_IDLE;
      abort_cnt_r <= 3'h0;
      xme_r <= 1'b0;
    end else begin
      case (tx_state_r)
        HLEC_TX_IDLE: begin
          if (cmd[HLEC_CMD_XTF] || cmd[HLEC_CMD_XIF]) begin
            tx_state_r <= HLEC_TX_SEND;
            xme_r <= cmd[HLEC_CMD_XME];
            auto_close_r <= cmd[HLEC_CMD_XIF] && cmd[HLEC_CMD_XME] && auto_mode;
          end
        end
        HLEC_TX_SEND: begin
          if (cmd[HLEC_CMD_XTF] || cmd[HLEC_CMD_XIF]) begin
            xme_r <= cmd[HLEC_CMD_XME];
            auto_close_r <= cmd[HLEC_CMD_XIF] && cmd[HLEC_CMD_XME] && auto_mode;
          end else if (tx_rel_r == 7'h00 && !tx_byte_valid_out) begin
            if (xme_r)
              tx_state_r <= auto_close_r ? HLEC_TX_WAIT_ACK : HLEC_TX_IDLE;
            else if (tx_cnt_r == 7'h00)
              tx_state_r <= HLEC_TX_ABORT;
          end
          abort_cnt_r <= 3'h0;
        end
        HLEC_TX_WAIT_ACK: begin
          if (rx_peer_ack_in || rx_peer_reject_in)
            tx_state_r <= HLEC_TX_IDLE;
        end
        default: begin
          abort_cnt_r <= abort_cnt_r + 3'h1;
          if (abort_cnt_r == 3'(HLEC_ABORT_ONES - 8'h01))
            tx_state_r <= HLEC_TX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      tx_byte_valid_out <= 1'b0;
      tx_byte_out <= 8'h00;
      tx_frame_end_out <= 1'b0;
      tx_abort_out <= 1'b0;
    end else begin
      tx_frame_end_out <= tx_state_r == HLEC_TX_SEND && xme_r && tx_rel_r == 7'h00
        && !tx_byte_valid_out && !cmd[HLEC_CMD_XTF] && !cmd[HLEC_CMD_XIF];
      tx_abort_out <= tx_state_r == HLEC_TX_ABORT; // seven ones, one per cycle
      // a reset must not leave a stale byte offered while the framer stalls
      if (cmd[HLEC_CMD_TRANSMITTER_RESET]) begin
        tx_byte_valid_out <= 1'b0;
      end else if (tx_byte_valid_out && !tx_byte_ready_in) begin
        tx_byte_valid_out <= 1'b1;
      end else if (tx_state_r == HLEC_TX_SEND && !cmd[HLEC_CMD_TRANSMITTER_RESET]
                   && tx_rel_r > 7'(tx_byte_valid_out)) begin
        tx_byte_valid_out <= 1'b1;
        tx_byte_out <= tx_mem[hlec_inc(tx_rptr_r) - 6'(!tx_byte_valid_out)];
      end else begin
        tx_byte_valid_out <= 1'b0;
      end
    end
  end

  // status flags: hardware set wins over the clear done by reading the register
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      main_r <= HLEC_STATUS_RST;
      ext_r <= HLEC_STATUS_RST;
    end else begin
      if (rd_in && addr_in == HLEC_ADDR_MAIN_STATUS)
        main_r <= 8'h00;
      if (rd_in && addr_in == HLEC_ADDR_EXT_STATUS)
        ext_r <= 8'h00;
      if ((rx_pool_done && !rx_frame_end_in && (!wait_ack_r || cmd_rx_ack))
          || (cmd_rx_ack && pend_valid_r && !pend_end_r))
        main_r[HLEC_MS_RPF] <= 1'b1;
      if ((rx_frame_end_in && (rx_wcnt_r != 7'h00 || rx_pool_done) && (!wait_ack_r || cmd_rx_ack))
          || (cmd_rx_ack && pend_valid_r && pend_end_r))
        main_r[HLEC_MS_RME] <= 1'b1;
      if (rx_frame_end_in && (rx_drop_r || (rx_byte_valid_in && rx_full)))
        ext_r[HLEC_ES_RFO] <= 1'b1;
      if (auto_mode && rx_protocol_err_in)
        ext_r[HLEC_ES_PCE] <= 1'b1;
      if ((tx_state_r == HLEC_TX_SEND && tx_rel_r == 7'h00 && !tx_byte_valid_out && !xme_r
           && tx_cnt_r != 7'h00 && cmd == 8'h00)
          || (tx_state_r == HLEC_TX_SEND && xme_r && !auto_close_r && tx_rel_r == 7'h00
           && !tx_byte_valid_out && cmd == 8'h00)
          || (tx_state_r == HLEC_TX_WAIT_ACK && rx_peer_ack_in))
        main_r[HLEC_MS_XPR] <= 1'b1;
      if (tx_line_err_in || (auto_mode && tx_state_r == HLEC_TX_WAIT_ACK && rx_peer_reject_in))
        ext_r[HLEC_ES_XMR] <= 1'b1;
      if (tx_state_r == HLEC_TX_SEND && !xme_r && tx_cnt_r == 7'h00 && tx_rel_r == 7'h00
          && !tx_byte_valid_out && cmd == 8'h00)
        ext_r[HLEC_ES_XDU] <= 1'b1;
      if (auto_mode && rx_status_change_in)
        main_r[HLEC_MS_RSC] <= 1'b1;
      if (ext_timer_expired_in || (auto_mode && t200_n200_expired_in))
        main_r[HLEC_MS_TIN] <= 1'b1;
    end
  end

  // control registers and command side effects
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      mode_r <= 8'h00;
      mask_r <= HLEC_MASK_RST;
      ext_mask_r <= HLEC_MASK_RST;
      rx_not_ready_out <= 1'b0;
      timer_start_out <= 1'b0;
    end else begin
      if (wr_in && addr_in == HLEC_ADDR_MODE)
        mode_r <= wdata_in;
      else if (wr_in && addr_in == HLEC_ADDR_MASK)
        mask_r <= wdata_in;
      else if (wr_in && addr_in == HLEC_ADDR_EXT_MASK)
        ext_mask_r <= wdata_in;
      if (cmd[HLEC_CMD_RNR])
        rx_not_ready_out <= 1'b1;
      else if (cmd[HLEC_CMD_RECEIVER_RESET])
        rx_not_ready_out <= 1'b0;
      timer_start_out <= cmd[HLEC_CMD_STI];
    end
  end

  // register read port, data one cycle after the strobe
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      rdata_out <= 8'h00;
      irq_out <= 1'b0;
    end else begin
      // irq lags the flags by one cycle so that it comes straight from a flop
      irq_out <= |(main_r & ~mask_r) || |(ext_r & ~ext_mask_r);
      if (rd_in) begin
        if (addr_in == HLEC_ADDR_RX_BUF)
          rdata_out <= rx_avail_r != 7'h00 ? rx_mem[rx_rptr_r] : 8'h00;
        else if (addr_in == HLEC_ADDR_MAIN_STATUS)
          rdata_out <= main_r;
        else if (addr_in == HLEC_ADDR_EXT_STATUS)
          rdata_out <= ext_r;
        else if (addr_in == HLEC_ADDR_RX_COUNT)
          rdata_out <= count_r;
        else if (addr_in == HLEC_ADDR_MODE)
          rdata_out <= mode_r;
        else if (addr_in == HLEC_ADDR_MASK)
          rdata_out <= mask_r;
        else if (addr_in == HLEC_ADDR_EXT_MASK)
          rdata_out <= ext_mask_r;
        else if (addr_in == HLEC_ADDR_TX_STATE)
          rdata_out <= {tx_cnt_r, tx_state_r == HLEC_TX_IDLE};
        else
          rdata_out <= HLEC_UNMAPPED;
      end else begin
        rdata_out <= 8'h00;
      end
    end
  end
endmodule : hlec_event_ctrl

/* File: pkg/hlec_pkg.sv */
// package: register map, command codes, status bit positions and reset values
package hlec_pkg;
  localparam int HLEC_POOL_BYTES = 32;
  localparam logic [5:0] HLEC_POOL_BYTES_6 = 6'h20;
  localparam logic [7:0] HLEC_ADDR_RX_BUF = 8'h00;
  localparam logic [7:0] HLEC_ADDR_TX_BUF = 8'h01;
  localparam logic [7:0] HLEC_ADDR_MAIN_STATUS = 8'h20;
  localparam logic [7:0] HLEC_ADDR_COMMAND = 8'h21;
  localparam logic [7:0] HLEC_ADDR_EXT_STATUS = 8'h24;
  localparam logic [7:0] HLEC_ADDR_RX_COUNT = 8'h25;
  localparam logic [7:0] HLEC_ADDR_MODE = 8'h22;
  localparam logic [7:0] HLEC_ADDR_MASK = 8'h23;
  localparam logic [7:0] HLEC_ADDR_EXT_MASK = 8'h26;
  localparam logic [7:0] HLEC_ADDR_TX_STATE = 8'h27;
  // command register bits
  localparam int HLEC_CMD_RMC = 7;
  localparam int HLEC_CMD_RECEIVER_RESET = 6;
  localparam int HLEC_CMD_RNR = 5;
  localparam int HLEC_CMD_STI = 4;
  localparam int HLEC_CMD_XTF = 3;
  localparam int HLEC_CMD_XIF = 2;
  localparam int HLEC_CMD_XME = 1;
  localparam int HLEC_CMD_TRANSMITTER_RESET = 0;
  // main status bits
  localparam int HLEC_MS_RPF = 7;
  localparam int HLEC_MS_RME = 6;
  localparam int HLEC_MS_XPR = 4;
  localparam int HLEC_MS_RSC = 5;
  localparam int HLEC_MS_TIN = 3;
  // extended status bits
  localparam int HLEC_ES_XMR = 7;
  localparam int HLEC_ES_XDU = 6;
  localparam int HLEC_ES_PCE = 5;
  localparam int HLEC_ES_RFO = 4;
  localparam logic [7:0] HLEC_STATUS_RST = 8'h00;
  localparam logic [7:0] HLEC_MASK_RST = 8'hFF;
  localparam logic [7:0] HLEC_ABORT_ONES = 8'h07;
  localparam logic [7:0] HLEC_UNMAPPED = 8'h00;
  typedef enum logic [1:0] {HLEC_TX_IDLE, HLEC_TX_SEND, HLEC_TX_WAIT_ACK, HLEC_TX_ABORT} hlec_tx_t;
endpackage : hlec_pkg

/* File: verification/hlec_event_ctrl_properties.sv */
// checker: port-level properties of the hdlc event and command block
`timescale 1ns/100ps
module hlec_event_ctrl_properties
  import hlec_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic tx_byte_ready_in,
  input wire logic tx_byte_valid_out,
  input wire logic [7:0] tx_byte_out,
  input wire logic tx_abort_out,
  input wire logic rx_not_ready_out,
  input wire logic timer_start_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  logic cmd;
  assign cmd = wr_in && addr_in == HLEC_ADDR_COMMAND;
  abort_seven_a: assert property ($rose(tx_abort_out) |-> tx_abort_out [*7] ##1 !tx_abort_out)
    else $error("abort sequence not seven cycles");
  transmitter_reset_abort_a: assert property (cmd && wdata_in[HLEC_CMD_TRANSMITTER_RESET] && tx_byte_valid_out
    |-> ##[1:3] tx_abort_out) else $error("reset of sending frame without abort");
  transmitter_reset_clear_a: assert property (cmd && wdata_in[HLEC_CMD_TRANSMITTER_RESET] |-> ##[1:3] !tx_byte_valid_out)
    else $error("transmit data left after transmitter reset");
  timer_pulse_a: assert property (cmd && wdata_in[HLEC_CMD_STI]
    |=> timer_start_out ##1 !timer_start_out) else $error("timer start not one pulse");
  rnr_set_a: assert property (cmd && wdata_in[HLEC_CMD_RNR] && !wdata_in[HLEC_CMD_RECEIVER_RESET]
    |=> rx_not_ready_out) else $error("not ready level not set");
  rnr_clear_a: assert property (cmd && wdata_in[HLEC_CMD_RECEIVER_RESET] |=> !rx_not_ready_out)
    else $error("not ready level not cleared");
  rnr_hold_a: assert property (!$past(cmd) |-> $stable(rx_not_ready_out))
    else $error("not ready level moved without command");
  tx_hold_a: assert property (tx_byte_valid_out && !tx_byte_ready_in && !cmd
    |=> tx_byte_valid_out && $stable(tx_byte_out)) else $error("offered byte not held");
endmodule : hlec_event_ctrl_properties
bind hlec_event_ctrl hlec_event_ctrl_properties chk (.*);

/* File: verification/hlec_framer_model.sv */
// partner: serial framer that takes transmit bytes and counts closes and aborts
`timescale 1ns/100ps
module hlec_framer_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic slow_in,
  input wire logic abort_in,
  input wire logic frame_end_in,
  output logic ready_out = 1'h0
);
  int n_end = 0;
  int n_abort = 0;
  logic abort_d = 1'h0;
  always @(posedge clk_in) begin
    // a slow framer accepts on random cycles so held bytes get exercised
    ready_out <= !rst_in && (!slow_in || $urandom % 3 == 0);
    abort_d <= abort_in;
    if (frame_end_in) n_end <= n_end + 1;
    if (abort_in && !abort_d) n_abort <= n_abort + 1;
  end
endmodule : hlec_framer_model

/* File: verification/testbench.sv */
// bench: register-port scenarios with framer model and queued expectations
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module testbench
  import hlec_pkg::*;
;
  logic ref_clk_in = 1'h0, rst_in = 1'h1, wr_in = 1'h0, rd_in = 1'h0, slow = 1'h0;
  logic rx_byte_valid_in = 1'h0, rx_frame_end_in = 1'h0, rd_d = 1'h0, tx_byte_ready_in;
  logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, rx_byte_in = 8'h00, rdata_out, tx_byte_out;
  logic [7:0] b, t;
  logic [6:0] ev = 7'h00;
  logic irq_out, tx_byte_valid_out, tx_frame_end_out, tx_abort_out;
  logic rx_not_ready_out, timer_start_out;
  logic [15:0] q;
  logic [15:0] rq[$];
  logic [7:0] txq[$];
  logic [7:0] rxq[$];
  int err_total = 0, n_tests = 0, cyc = 0;
  always #10 ref_clk_in = ~ref_clk_in;
  hlec_event_ctrl dut (.*, .rx_protocol_err_in(ev[0]), .rx_status_change_in(ev[1]),
    .rx_peer_ack_in(ev[2]), .rx_peer_reject_in(ev[3]), .tx_line_err_in(ev[4]),
    .ext_timer_expired_in(ev[5]), .t200_n200_expired_in(ev[6]));
  hlec_framer_model m (.clk_in(ref_clk_in), .rst_in(rst_in), .slow_in(slow),
    .abort_in(tx_abort_out), .frame_end_in(tx_frame_end_out), .ready_out(tx_byte_ready_in));
  always @(posedge ref_clk_in) begin
    rd_d <= rd_in;
    cyc <= cyc + 1;
    if (rd_d) begin
      q = rq.pop_front();
      if (q[15:8] != 8'h00) `CHK("rdata", q[7:0] & q[15:8], rdata_out & q[15:8])
    end
    if (tx_byte_valid_out && tx_byte_ready_in && txq.size() > 0) begin
      t = txq.pop_front();
      `CHK("tx_byte", t, tx_byte_out)
    end
    if (cyc == 20000) begin
      err_total++;
      report_and_stop();
    end
  end
  task automatic wrr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'h1;
    @(posedge ref_clk_in);
    wr_in <= 1'h0;
  endtask : wrr
  // mask selects the bits whose value is known; zero mask only clears a status
  task automatic rdr(input logic [7:0] a, input logic [7:0] mk, input logic [7:0] e);
    @(posedge ref_clk_in);
    rq.push_back({mk, e});
    addr_in <= a;
    rd_in <= 1'h1;
    @(posedge ref_clk_in);
    rd_in <= 1'h0;
  endtask : rdr
  task automatic pulse(input logic [6:0] p);
    @(posedge ref_clk_in);
    ev <= p;
    @(posedge ref_clk_in);
    ev <= 7'h00;
  endtask : pulse
  task automatic rx_feed(input int n, input bit fin);
    repeat (n) begin
      @(posedge ref_clk_in);
      b = 8'($urandom);
      rxq.push_back(b);
      rx_byte_in <= b;
      rx_byte_valid_in <= 1'h1;
    end
    @(posedge ref_clk_in);
    rx_byte_valid_in <= 1'h0;
    rx_frame_end_in <= fin;
    @(posedge ref_clk_in);
    rx_frame_end_in <= 1'h0;
  endtask : rx_feed
  task automatic rx_drain(input int n);
    repeat (n) rdr(HLEC_ADDR_RX_BUF, 8'hFF, rxq.pop_front());
  endtask : rx_drain
  task automatic tx_fill(input int n, input bit keep);
    repeat (n) begin
      b = 8'($urandom);
      if (keep) txq.push_back(b);
      wrr(HLEC_ADDR_TX_BUF, b);
    end
  endtask : tx_fill
  task automatic wait_ev(input bit ab);
    int k0;
    k0 = ab ? m.n_abort : m.n_end;
    for (int i = 0; i < 400 && k0 == (ab ? m.n_abort : m.n_end); i++) @(posedge ref_clk_in);
  endtask : wait_ev
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  initial begin
    void'($urandom(32'hD47190C5));
    repeat (8) @(posedge ref_clk_in);
    rst_in <= 1'h0;
    wrr(HLEC_ADDR_MASK, 8'h00);
    wrr(HLEC_ADDR_EXT_MASK, 8'h00);
    rdr(HLEC_ADDR_MAIN_STATUS, 8'h00, 8'h00);
    rdr(HLEC_ADDR_EXT_STATUS, 8'h00, 8'h00);
    rdr(8'h30, 8'hFF, HLEC_UNMAPPED);
    tx_fill(3, 1);
    wrr(HLEC_ADDR_COMMAND, 8'h0A);
    wait_ev(0);
    `CHK("closes", 1, m.n_end)
    repeat (2) @(posedge ref_clk_in);
    `CHK("irq_set", 1'h1, irq_out)
    rdr(HLEC_ADDR_MAIN_STATUS, 8'h10, 8'h10);
    rdr(HLEC_ADDR_MAIN_STATUS, 8'h10, 8'h00);
    `CHK("irq_clear", 1'h0, irq_out)
    slow <= 1'h1;
    tx_fill(2, 1);
    wrr(HLEC_ADDR_COMMAND, 8'h08);
    wait_ev(1);
    `CHK("aborts", 1, m.n_abort)
    rdr(HLEC_ADDR_EXT_STATUS, 8'h40, 8'h40);
    tx_fill(12, 0);
    wrr(HLEC_ADDR_COMMAND, 8'h04);
    for (int i = 0; i < 40 && !tx_byte_valid_out; i++) @(posedge ref_clk_in);
    wrr(HLEC_ADDR_COMMAND, 8'h01);
    wait_ev(1);
    `CHK("aborts", 2, m.n_abort)
    wrr(HLEC_ADDR_COMMAND, 8'h30);
    slow <= 1'h0;
    tx_fill(1, 1);
    wrr(HLEC_ADDR_COMMAND, 8'h0A);
    wait_ev(0);
    `CHK("tx_left", 0, txq.size())
    rdr(HLEC_ADDR_MAIN_STATUS, 8'h00, 8'h00);
    rdr(HLEC_ADDR_EXT_STATUS, 8'h00, 8'h00);
    rx_feed(32, 0);
    rdr(HLEC_ADDR_MAIN_STATUS, 8'hC0, 8'h80);
    rx_feed(5, 1);
    rdr(HLEC_ADDR_MAIN_STATUS, 8'hC0, 8'h00);
    rx_drain(32);
    wrr(HLEC_ADDR_COMMAND, 8'h80);
    rdr(HLEC_ADDR_MAIN_STATUS, 8'hC0, 8'h40);
    rdr(HLEC_ADDR_RX_COUNT, 8'h1F, 8'h05);
    rx_drain(5);
    wrr(HLEC_ADDR_COMMAND, 8'h80);
    rx_feed(64, 0);
    rx_feed(1, 1);
    rdr(HLEC_ADDR_EXT_STATUS, 8'h10, 8'h10);
    wrr(HLEC_ADDR_COMMAND, 8'h40);
    rxq.delete();
    rdr(HLEC_ADDR_MAIN_STATUS, 8'h00, 8'h00);
    pulse(7'h33);
    repeat (20) @(posedge ref_clk_in);
    rdr(HLEC_ADDR_EXT_STATUS, 8'hA0, 8'h80);
    rdr(HLEC_ADDR_MAIN_STATUS, 8'h28, 8'h08);
    wrr(HLEC_ADDR_MODE, 8'h01);
    // peer reject only counts while a close waits for its ack, so the line error sets repeat
    pulse(7'h5B);
    rdr(HLEC_ADDR_EXT_STATUS, 8'hA0, 8'hA0);
    rdr(HLEC_ADDR_MAIN_STATUS, 8'h28, 8'h28);
    tx_fill(1, 1);
    wrr(HLEC_ADDR_COMMAND, 8'h06);
    wait_ev(0);
    `CHK("closes", 3, m.n_end)
    rdr(HLEC_ADDR_MAIN_STATUS, 8'h10, 8'h00);
    pulse(7'h04);
    rdr(HLEC_ADDR_MAIN_STATUS, 8'h10, 8'h10);
    repeat (3) @(posedge ref_clk_in);
    report_and_stop();
  end
endmodule : testbench
